//--- design/ssc_channel.sv
// Serial channel with clock synchronous and 16x asynchronous modes
//
// Overview of operation
// - Transmit bit changes on each serial clock fall
// - Data valid and captured on rising edge
// - Characters shifted least significant bit first
// - Line holds last bit level after character
// - Synchronous characters are always eight bits
// - No parity or multiprocessor bit appended
// - Clock source chosen by mode, enable bits
// - Internal clock driven out on clock pin in synchronous mode
// - Eight clock pulses per internal-clock character
// - Clock output idles high between transfers
// - Transmitter and receiver run independently, full duplex
// - Both directions double buffered for gapless streams
// - Overrun detected only on the receive side
// - Internal receive clock runs until receive disabled
// - Asynchronous receiver samples at sixteen times bitrate
//
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module ssc_channel (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    // AXI4-Lite write address and data
    input  wire logic [ssc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output var  logic                       s_axi_awready,
    input  wire logic [ssc_pkg::DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output var  logic                       s_axi_wready,
    // AXI4-Lite write response
    output var  logic [1:0]                 s_axi_bresp,
    output var  logic                       s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    // AXI4-Lite read
    input  wire logic [ssc_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output var  logic                       s_axi_arready,
    output var  logic [ssc_pkg::DATA_W-1:0] s_axi_rdata,
    output var  logic [1:0]                 s_axi_rresp,
    output var  logic                       s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    // Serial pins
    input  wire logic                       sck_in,
    output var  logic                       sck_out,
    output var  logic                       sck_oe_n,
    output var  logic                       txd,
    input  wire logic                       rxd
);
    import ssc_pkg::*;

    logic [7:0]        serial_mode_reg;
    logic [7:0]        serial_control_reg;
    logic [7:0]        baud_div;
    logic [7:0]        tdr;
    logic              tdr_full;
    logic [7:0]        tsr;
    logic              tx_active;
    logic [7:0]        rdr;
    logic              rdr_full;
    logic [7:0]        rsr;
    logic              overrun;
    logic              framing_err;
    logic [1:0]        rxd_sync;
    logic [1:0]        sck_sync;
    logic              sck_prev;
    logic [7:0]        brg_cnt;
    logic              sck_run;
    logic [2:0]        bit_idx;
    ssc_async_t        atx_state;
    logic [3:0]        atx_cnt;
    logic [2:0]        atx_bit;
    ssc_async_t        arx_state;
    logic [3:0]        arx_cnt;
    logic [2:0]        arx_bit;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [7:0]        w_data_q;
    logic              w_lane0_q;

    logic sync_mode;
    logic tx_enable;
    logic receive_enable;
    logic clock_enable_hi;
    logic clock_enable_lo;
    logic int_clk;
    logic rxd_s;
    logic ext_rise;
    logic ext_fall;
    logic brg_tick;
    logic start_cond;
    logic int_fall;
    logic int_rise;
    logic int_stop;
    logic fall_ev;
    logic rise_ev;
    logic tick_a;
    logic sync_load;
    logic async_load;
    logic rx_done;
    logic [7:0] rx_word;
    logic wr_fire;
    logic wr_ok;
    logic rd_fire;
    logic rd_rxd;

    assign sync_mode       = serial_mode_reg[MODE_SYNC];
    assign tx_enable       = serial_control_reg[CTRL_TE];
    assign receive_enable  = serial_control_reg[CTRL_RE];
    assign clock_enable_lo = serial_control_reg[CTRL_CKL];
    assign clock_enable_hi = serial_control_reg[CTRL_CKH];
    // Low enable bit only matters for async clock output, not provided here
    assign int_clk         = !clock_enable_hi;

    // Pin synchronisers; edge detect reads only the second stage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rxd_sync <= 2'b11;
            sck_sync <= 2'b11;
            sck_prev <= 1'b1;
        end else begin
            rxd_sync <= {rxd_sync[0], rxd};
            sck_sync <= {sck_sync[0], sck_in};
            sck_prev <= sck_sync[1];
        end
    end
    assign rxd_s    = rxd_sync[1];
    assign ext_rise = sck_sync[1] && !sck_prev;
    assign ext_fall = !sck_sync[1] && sck_prev;

    // Baud rate generator
    assign brg_tick = (brg_cnt == baud_div);
    always_ff @(posedge clk) begin
        if (!rst_n || brg_tick) begin
            brg_cnt <= 8'h00;
        end else begin
            brg_cnt <= brg_cnt + 8'h01;
        end
    end

    // Synchronous clock events, internal or from the pin
    always_comb begin
        start_cond = (tx_enable && tdr_full) || receive_enable;
        int_fall = 1'b0;
        int_rise = 1'b0;
        int_stop = 1'b0;
        if (sync_mode && int_clk && brg_tick) begin
            if (!sck_run) begin
                int_fall = start_cond;
            end else if (!sck_out) begin
                int_rise = 1'b1;
            end else if (bit_idx != 3'h0 || start_cond) begin
                int_fall = 1'b1;
            end else begin
                int_stop = 1'b1;
            end
        end
        fall_ev = int_clk ? int_fall : (sync_mode && ext_fall);
        rise_ev = int_clk ? int_rise : (sync_mode && ext_rise);
        tick_a  = !sync_mode && (clock_enable_hi ? ext_rise : brg_tick);
    end

    // Serial clock output; high whenever idle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sck_out  <= 1'b1;
            sck_run  <= 1'b0;
            sck_oe_n <= 1'b1;
        end else begin
            sck_oe_n <= !(sync_mode && int_clk);
            if (!(sync_mode && int_clk)) begin
                sck_out <= 1'b1;
                sck_run <= 1'b0;
            end else if (int_fall) begin
                sck_out <= 1'b0;
                sck_run <= 1'b1;
            end else if (int_rise) begin
                sck_out <= 1'b1;
            end else if (int_stop) begin
                sck_run <= 1'b0;
            end
        end
    end

    // Bit position of the synchronous character; fixed at eight bits
    always_ff @(posedge clk) begin
        if (!rst_n || !sync_mode || !(tx_enable || receive_enable || sck_run)) begin
            bit_idx <= 3'h0;
        end else if (rise_ev) begin
            bit_idx <= bit_idx + 3'h1;
        end
    end

    // Transmitter: both modes share the shift register and the pin
    assign sync_load  = fall_ev && bit_idx == 3'h0 && tx_enable && tdr_full;
    assign async_load = tick_a && atx_state == SSC_IDLE && tx_enable && tdr_full;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            txd       <= 1'b1;
            tsr       <= 8'h00;
            tx_active <= 1'b0;
            atx_state <= SSC_IDLE;
            atx_cnt   <= 4'h0;
            atx_bit   <= 3'h0;
        end else if (sync_mode) begin
            atx_state <= SSC_IDLE;
            if (fall_ev && bit_idx == 3'h0) begin
                tx_active <= sync_load;
                if (sync_load) begin
                    tsr <= tdr;
                    txd <= tdr[0];
                end
            end else if (fall_ev && tx_active) begin
                txd <= tsr[bit_idx];
            end else if (rise_ev && bit_idx == BIT_LAST) begin
                tx_active <= 1'b0;
            end
        end else begin
            tx_active <= atx_state != SSC_IDLE;
            if (tick_a) begin
                atx_cnt <= atx_cnt + 4'h1;
            end
            unique case (atx_state)
                SSC_IDLE: begin
                    atx_cnt <= 4'h0;
                    txd     <= 1'b1;
                    if (async_load) begin
                        tsr       <= tdr;
                        txd       <= 1'b0;
                        atx_state <= SSC_START;
                    end
                end
                SSC_START: begin
                    if (tick_a && atx_cnt == OVS_LAST) begin
                        txd       <= tsr[0];
                        atx_bit   <= 3'h0;
                        atx_state <= SSC_DATA;
                    end
                end
                SSC_DATA: begin
                    if (tick_a && atx_cnt == OVS_LAST) begin
                        if (atx_bit == BIT_LAST) begin
                            txd       <= 1'b1;
                            atx_state <= SSC_STOP;
                        end else begin
                            atx_bit <= atx_bit + 3'h1;
                            txd     <= tsr[atx_bit + 3'h1];
                        end
                    end
                end
                SSC_STOP: begin
                    if (tick_a && atx_cnt == OVS_LAST) begin
                        atx_state <= SSC_IDLE;
                    end
                end
            endcase
        end
    end

    // Asynchronous receiver, sixteen ticks per bit, each data bit sampled once at mid-bit
    always_ff @(posedge clk) begin
        if (!rst_n || sync_mode || !receive_enable) begin
            arx_state <= SSC_IDLE;
            arx_cnt   <= 4'h0;
            arx_bit   <= 3'h0;
        end else if (tick_a) begin
            arx_cnt <= arx_cnt + 4'h1;
            unique case (arx_state)
                SSC_IDLE: begin
                    arx_cnt <= 4'h0;
                    if (!rxd_s) begin
                        arx_state <= SSC_START;
                    end
                end
                SSC_START: begin
                    if (arx_cnt == OVS_HALF) begin
                        arx_cnt   <= 4'h0;
                        arx_bit   <= 3'h0;
                        arx_state <= rxd_s ? SSC_IDLE : SSC_DATA;
                    end
                end
                SSC_DATA: begin
                    if (arx_cnt == OVS_LAST && arx_bit == BIT_LAST) begin
                        arx_state <= SSC_STOP;
                    end else if (arx_cnt == OVS_LAST) begin
                        arx_bit <= arx_bit + 3'h1;
                    end
                end
                SSC_STOP: begin
                    if (arx_cnt == OVS_LAST) begin
                        arx_state <= SSC_IDLE;
                    end
                end
            endcase
        end
    end

    // Receive shift register, written by whichever mode is active
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rsr <= 8'h00;
        end else if (sync_mode && rise_ev && receive_enable) begin
            rsr[bit_idx] <= rxd_s;
        end else if (tick_a && arx_state == SSC_DATA && arx_cnt == OVS_LAST) begin
            rsr[arx_bit] <= rxd_s;
        end
    end

    always_comb begin
        rx_word = {rxd_s, rsr[6:0]};
        rx_done = sync_mode && rise_ev && receive_enable && bit_idx == BIT_LAST;
        if (!sync_mode) begin
            rx_word = rsr;
            rx_done = tick_a && arx_state == SSC_STOP && arx_cnt == OVS_LAST;
        end
    end

    // AXI4-Lite write channel
    assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wr_ok   = aw_addr_q <= OFF_STAT && aw_addr_q[1:0] == 2'b00;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            aw_addr_q     <= '0;
            w_data_q      <= 8'h00;
            w_lane0_q     <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                aw_addr_q     <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                w_data_q     <= s_axi_wdata[7:0];
                w_lane0_q    <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Control registers and transmit buffer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            serial_mode_reg    <= MODE_RST;
            serial_control_reg <= CTRL_RST;
            baud_div           <= BAUD_RST;
            tdr                <= 8'h00;
            tdr_full           <= 1'b0;
        end else begin
            if (sync_load || async_load) begin
                tdr_full <= 1'b0;
            end
            if (wr_fire && w_lane0_q) begin
                unique case (aw_addr_q)
                    OFF_MODE: serial_mode_reg <= w_data_q;
                    OFF_CTRL: serial_control_reg <= w_data_q;
                    OFF_BAUD: baud_div <= w_data_q;
                    OFF_TXD: begin
                        tdr      <= w_data_q;
                        tdr_full <= 1'b1;
                    end
                    default: ;
                endcase
            end
        end
    end

    // Receive buffer and error flags; a new event beats a clear
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign rd_rxd  = rd_fire && s_axi_araddr == OFF_RXD;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdr         <= 8'h00;
            rdr_full    <= 1'b0;
            overrun     <= 1'b0;
            framing_err <= 1'b0;
        end else begin
            if (rd_rxd) begin
                rdr_full <= 1'b0;
            end
            if (wr_fire && w_lane0_q && aw_addr_q == OFF_STAT) begin
                if (w_data_q[ST_OVR]) begin
                    overrun <= 1'b0;
                end
                if (w_data_q[ST_FER]) begin
                    framing_err <= 1'b0;
                end
            end
            if (rx_done && rdr_full && !rd_rxd) begin
                overrun <= 1'b1;
            end else if (rx_done) begin
                rdr      <= rx_word;
                rdr_full <= 1'b1;
            end
            if (rx_done && !sync_mode && !rxd_s) begin
                framing_err <= 1'b1;
            end
        end
    end

    // AXI4-Lite read channel
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            if (rd_fire) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= RESP_OKAY;
                s_axi_rdata   <= '0;
                unique case (s_axi_araddr)
                    OFF_MODE: s_axi_rdata[7:0] <= serial_mode_reg;
                    OFF_CTRL: s_axi_rdata[7:0] <= serial_control_reg;
                    OFF_BAUD: s_axi_rdata[7:0] <= baud_div;
                    OFF_TXD:  s_axi_rdata[7:0] <= tdr;
                    OFF_RXD:  s_axi_rdata[7:0] <= rdr;
                    OFF_STAT: begin
                        s_axi_rdata[ST_TDRE] <= !tdr_full;
                        s_axi_rdata[ST_RDRF] <= rdr_full;
                        s_axi_rdata[ST_OVR]  <= overrun;
                        s_axi_rdata[ST_TEND] <= !tdr_full && !tx_active;
                        s_axi_rdata[ST_FER]  <= framing_err;
                    end
                    default: s_axi_rresp <= RESP_SLVERR;
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule : ssc_channel
`default_nettype wire

//--- design/ssc_pkg.sv
// Constants, register map and state codes of the synchronous serial channel
package ssc_pkg;
    localparam int unsigned ADDR_W = 6;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned CHAR_BITS = 8;
    localparam logic [ADDR_W-1:0] OFF_MODE = 6'h00;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 6'h04;
    localparam logic [ADDR_W-1:0] OFF_BAUD = 6'h08;
    localparam logic [ADDR_W-1:0] OFF_TXD  = 6'h0c;
    localparam logic [ADDR_W-1:0] OFF_RXD  = 6'h10;
    localparam logic [ADDR_W-1:0] OFF_STAT = 6'h14;
    // serial_mode_reg bits
    localparam int unsigned MODE_SYNC = 0;
    // serial_control_reg bits
    localparam int unsigned CTRL_TE  = 0;
    localparam int unsigned CTRL_RE  = 1;
    localparam int unsigned CTRL_CKL = 2;
    localparam int unsigned CTRL_CKH = 3;
    // Status bits
    localparam int unsigned ST_TDRE = 0;
    localparam int unsigned ST_RDRF = 1;
    localparam int unsigned ST_OVR  = 2;
    localparam int unsigned ST_TEND = 3;
    localparam int unsigned ST_FER  = 4;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] BAUD_RST = 8'h0f;
    localparam logic [3:0] OVS_LAST = 4'hf;
    localparam logic [3:0] OVS_HALF = 4'h7;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [3:0] {
        SSC_IDLE  = 4'b0001,
        SSC_START = 4'b0010,
        SSC_DATA  = 4'b0100,
        SSC_STOP  = 4'b1000
    } ssc_async_t;
endpackage : ssc_pkg

//--- testbench/ssc_channel_properties.sv
// Checker of the serial channel's bus handshakes and serial pin timing
`timescale 1ns/100ps
`default_nettype none
module ssc_channel_chk (
    // Clock, reset and bus handshakes
    input wire logic                       clk, rst_n, s_axi_awvalid, s_axi_awready,
    input wire logic                       s_axi_wvalid, s_axi_wready, s_axi_bvalid,
    input wire logic                       s_axi_bready, s_axi_arvalid, s_axi_arready,
    input wire logic                       s_axi_rvalid, s_axi_rready,
    // Bus payloads
    input wire logic [1:0]                 s_axi_bresp, s_axi_rresp,
    input wire logic [ssc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [ssc_pkg::DATA_W-1:0] s_axi_rdata,
    // Serial pins
    input wire logic                       sck_out, sck_oe_n, txd
);
    import ssc_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_clk_low_bound: assert property ($fell(sck_out) |-> ##[1:256] sck_out)
        else $error("serial clock held low too long");
    chk_tx_on_fall: assert property (!sck_oe_n && !$past(sck_oe_n) && $changed(txd)
        |-> $fell(sck_out))
        else $error("transmit data moved away from a clock fall");
    chk_tx_at_rise: assert property (!sck_oe_n && $rose(sck_out) |-> $stable(txd))
        else $error("transmit data moved at a clock rise");
    chk_clk_idle_high: assert property (sck_oe_n |-> sck_out)
        else $error("undriven clock output not high");
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    chk_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data late");
    chk_read_release: assert property (s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid && s_axi_arready)
        else $error("read not released after handshake");
    chk_unmapped_read: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr > OFF_STAT |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0)
        else $error("unmapped read not refused");
    cover property ($fell(sck_out));
    cover property (!sck_oe_n && $rose(sck_out));
    cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule : ssc_channel_chk
bind ssc_channel ssc_channel_chk u_chk (.clk(clk), .rst_n(rst_n),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_bresp(s_axi_bresp), .s_axi_rresp(s_axi_rresp),
    .s_axi_araddr(s_axi_araddr), .s_axi_rdata(s_axi_rdata), .sck_out(sck_out),
    .sck_oe_n(sck_oe_n), .txd(txd));
`default_nettype wire

//--- testbench/ssc_peer.sv
// Serial peer device on the channel's clock and data pins
`timescale 1ns/100ps
`default_nettype none
module ssc_peer (
    // Clock
    input  wire logic clk,
    // Channel pins
    input  wire logic sck_out, sck_oe_n, txd,
    output var  logic sck_in, rxd
);
    logic [7:0] tx_byte = 8'h00;
    logic [7:0] cap     = 8'h00;
    logic [2:0] nbit    = 3'h0;
    logic       peer_sck = 1'b1;
    int         nrise   = 0;
    realtime    t_last  = 0;
    realtime    per_max = 0;
    logic [7:0] got [$];
    // Pin level: the channel drives it only with its enable low
    assign sck_in = sck_oe_n ? peer_sck : sck_out;
    initial rxd = 1'b1;
    always @(negedge sck_in) begin
        rxd <= tx_byte[nbit];
        nbit <= nbit + 3'h1;
    end
    always @(posedge sck_in) if ($realtime > 20) begin
        cap = {txd, cap[7:1]};
        if ($realtime - t_last > per_max) per_max = $realtime - t_last;
        t_last = $realtime;
        if (nrise % 8 == 7) got.push_back(cap);
        nrise <= nrise + 1;
    end
    // Clock stands high outside the character, as a real master's would
    task automatic ext_char(input int hp);
        repeat (8) begin
            repeat (hp) @(posedge clk);
            peer_sck <= 1'b0;
            repeat (hp) @(posedge clk);
            peer_sck <= 1'b1;
        end
    endtask : ext_char
    task automatic async_char(input logic [7:0] b, input int bt);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd <= fr[i];
            repeat (bt) @(posedge clk);
        end
    endtask : async_char
endmodule : ssc_peer
`default_nettype wire

//--- testbench/tb_sync_serial_channel.sv
// Testbench of the serial channel: register access and serial traffic
`timescale 1ns/100ps
`default_nettype none
module tb_sync_serial_channel;
    import ssc_pkg::*;
    logic              clk = 1'b0, rst_n = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [DATA_W-1:0] wdata = '0, rdata, rd;
    logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic              arvalid = 1'b0, rready = 1'b0;
    logic              awready, wready, bvalid, arready, rvalid;
    logic              sck_in, sck_out, sck_oe_n, txd, rxd;
    logic [1:0]        bresp, rresp, r2;
    int                error_cnt = 0, comparisons = 0, cyc = 0, b, g;
    ssc_channel u_dut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .sck_in(sck_in), .sck_out(sck_out),
        .sck_oe_n(sck_oe_n), .txd(txd), .rxd(rxd));
    ssc_peer u_peer (.clk(clk), .sck_out(sck_out), .sck_oe_n(sck_oe_n), .txd(txd),
        .sck_in(sck_in), .rxd(rxd));
    initial forever #10 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            give_verdict();
        end
    end
    task automatic give_verdict;
        if (error_cnt == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] v);
        comparisons++;
        if (v !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", n, e, v);
        end
    endtask : chk
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r2 = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd_reg(input logic [ADDR_W-1:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd = rdata;
        r2 = rresp;
        rready <= 1'b0;
    endtask : rd_reg
    // Bounded by the global cycle ceiling
    task automatic wait_rise(input int n);
        while (u_peer.nrise < n) @(posedge clk);
    endtask : wait_rise
    task automatic t_reset;
        chk("sck_out", 32'h1, sck_out);
        chk("sck_oe_n", 32'h1, sck_oe_n);
        chk("txd", 32'h1, txd);
        rd_reg(OFF_BAUD);
        chk("baud", {24'h000000, BAUD_RST}, rd);
        rd_reg(OFF_STAT);
        chk("stat", 32'h9, rd);
        rd_reg(6'h18);
        chk("rresp", {30'h0, RESP_SLVERR}, r2);
        chk("rdata", 32'h0, rd);
        wr(6'h1c, 8'h55);
        chk("bresp", {30'h0, RESP_SLVERR}, r2);
    endtask : t_reset
    task automatic t_int_tx;
        wr(OFF_BAUD, 8'h02);
        wr(OFF_MODE, 8'h01);
        wr(OFF_TXD, 8'h35);
        b = u_peer.nrise;
        wr(OFF_CTRL, 8'h01);
        wait_rise(b + 8);
        repeat (60) @(posedge clk);
        chk("pulses", 32'h8, u_peer.nrise - b);
        chk("tx char", 32'h35, u_peer.got[$]);
        chk("txd hold", 32'h0, txd);
        chk("sck idle", 32'h1, sck_out);
        chk("sck drive", 32'h0, sck_oe_n);
        rd_reg(OFF_STAT);
        chk("stat tx", 32'h9, rd);
    endtask : t_int_tx
    task automatic t_duplex;
        u_peer.tx_byte = 8'hc3;
        wr(OFF_TXD, 8'h12);
        b = u_peer.nrise;
        g = u_peer.got.size();
        wr(OFF_CTRL, 8'h03);
        wait_rise(b + 1);
        u_peer.per_max = 0;
        wr(OFF_TXD, 8'h9e);
        wait_rise(b + 8);
        rd_reg(OFF_RXD);
        chk("rx char", 32'hc3, rd);
        wait_rise(b + 24);
        chk("period", 32'h78, int'(u_peer.per_max));
        wr(OFF_CTRL, 8'h00);
        repeat (150) @(posedge clk);
        chk("char end", 32'h0, (u_peer.nrise - b) % 8);
        chk("tx first", 32'h12, u_peer.got[g]);
        chk("tx next", 32'h9e, u_peer.got[g + 1]);
        rd_reg(OFF_STAT);
        chk("overrun", 32'hf, rd);
        wr(OFF_STAT, 8'h04);
        rd_reg(OFF_RXD);
        chk("kept char", 32'hc3, rd);
        rd_reg(OFF_STAT);
        chk("ovr clear", 32'h9, rd);
    endtask : t_duplex
    task automatic t_ext;
        u_peer.tx_byte = 8'h5d;
        wr(OFF_TXD, 8'h6b);
        wr(OFF_CTRL, 8'h0b);
        b = u_peer.nrise;
        u_peer.ext_char(8);
        chk("ext pin", 32'h1, sck_oe_n);
        repeat (20) @(posedge clk);
        chk("ext pulses", 32'h8, u_peer.nrise - b);
        chk("ext tx", 32'h6b, u_peer.got[$]);
        rd_reg(OFF_RXD);
        chk("ext rx", 32'h5d, rd);
        wr(OFF_CTRL, 8'h00);
    endtask : t_ext
    task automatic t_async;
        u_peer.rxd <= 1'b1;
        wr(OFF_MODE, 8'h00);
        wr(OFF_CTRL, 8'h02);
        repeat (40) @(posedge clk);
        u_peer.async_char(8'h4e, 48);
        repeat (20) @(posedge clk);
        rd_reg(OFF_STAT);
        chk("async stat", 32'h2, rd & 32'h16);
        rd_reg(OFF_RXD);
        chk("async rx", 32'h4e, rd);
    endtask : t_async
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_int_tx();
        t_duplex();
        t_ext();
        t_async();
        give_verdict();
    end
endmodule : tb_sync_serial_channel
`default_nettype wire
